// file: logic/vrpm_pkg.sv
// package for the vector reciprocal, population count and mask unit
package vrpm_pkg;
    localparam int ELEM_W = 64;
    localparam int NUM_ELEM = 64;
    localparam int IDX_W = 6;
    localparam int VL_W = 7;
    localparam int OPC_W = 3;
    localparam logic [2:0] OPC_RECIP = 3'h0;
    localparam logic [2:0] OPC_POP = 3'h1;
    localparam logic [2:0] OPC_PARITY = 3'h2;
    localparam logic [2:0] TEST_ZERO = 3'h0;
    localparam logic [2:0] TEST_NONZERO = 3'h1;
    localparam logic [2:0] TEST_POS = 3'h2;
    localparam logic [2:0] TEST_NEG = 3'h3;
    localparam logic [2:0] TEST_LIST_BIT = 3'h4;
    localparam logic [63:0] MASK_RESET = 64'h0;
    localparam int SIGN_BIT = 63;
    localparam int EXP_HI = 62;
    localparam int EXP_LO = 48;
    localparam int COEF_HI = 47;
    localparam int COEF_LO = 0;
    localparam int COEF_NORM_BIT = 47;
    localparam logic [14:0] EXP_BIAS2 = 15'h7ffe;
    localparam int RECIP_TBL_BITS = 8;
    typedef enum logic [2:0] {
        VRPM_IDLE = 3'b001,
        VRPM_RUN = 3'b010,
        VRPM_DONE = 3'b100
    } vrpm_state_t;
    typedef enum logic [1:0] {
        VRPM_UNIT_RECIP = 2'b01,
        VRPM_UNIT_LOGIC = 2'b10
    } vrpm_unit_t;
endpackage

// file: logic/vrpm_unit.sv
// element-wise reciprocal, population count, parity and mask-test datapath
// Summary of operation
// - reciprocal opcode writes approximate reciprocal of each source element to destination
// - zero or unnormalized source gives an unspecified reciprocal result
// - reciprocal performs exactly vector length element operations
// - pop count and parity run in the reciprocal approximation unit
// - pop count writes number of one bits per element, vector length elements
// - parity writes 0 for even one-bit count, 1 for odd
// - mask-test low digit 0..3 selects zero, nonzero, positive, negative
// - 64-bit condition mask, one bit per element of the tested register
// - mask bit set when condition holds, cleared otherwise
// - only vector length elements are tested
// - whole mask cleared before testing, bits beyond length stay zero
// - a zero element counts as positive
// - element 0 maps to leftmost mask bit, then onward rightwards
// - digits 4..7 also write compressed list of matching indices to destination
// - all mask-test variants run in the vector logical unit
`timescale 1ns/100ps
`default_nettype none
module vrpm_unit
    import vrpm_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic i_is_test,
    input wire logic [vrpm_pkg::OPC_W-1:0] i_opcode,
    input wire logic [vrpm_pkg::VL_W-1:0] i_vector_length_reg,
    input wire logic [vrpm_pkg::ELEM_W-1:0] i_source_vector_reg,
    input wire logic i_mask_wr,
    input wire logic [vrpm_pkg::ELEM_W-1:0] i_mask_wdata,
    output logic o_busy,
    output logic o_done,
    output logic [vrpm_pkg::IDX_W-1:0] o_src_index,
    output logic o_dest_we,
    output logic [vrpm_pkg::IDX_W-1:0] o_dest_index,
    output logic [vrpm_pkg::ELEM_W-1:0] o_dest_vector_reg,
    output logic [1:0] o_unit,
    output logic [vrpm_pkg::ELEM_W-1:0] o_vector_condition_mask
);
    import vrpm_pkg::*;

    vrpm_state_t state_reg, state_next;
    logic is_test_reg, is_test_next;
    logic [OPC_W-1:0] opc_reg, opc_next;
    logic [VL_W-1:0] len_reg, len_next;
    logic [VL_W-1:0] cnt_reg, cnt_next;
    logic [IDX_W-1:0] list_reg, list_next;
    logic [ELEM_W-1:0] mask_reg, mask_next;
    logic we_reg, we_next;
    logic [IDX_W-1:0] widx_reg, widx_next;
    logic [ELEM_W-1:0] wdata_reg, wdata_next;
    logic done_reg, done_next;
    logic [1:0] unit_reg, unit_next;

    logic [6:0] pop;
    logic cond;
    logic [ELEM_W-1:0] recip;
    logic [14:0] exp_in;
    logic [RECIP_TBL_BITS-1:0] top;
    logic [RECIP_TBL_BITS:0] rtop;

    // population count and parity of the current source element
    always_comb begin
        pop = 7'h00;
        for (int b = 0; b < ELEM_W; b++) begin
            pop = pop + {6'h00, i_source_vector_reg[b]};
        end
    end

    // condition test; a zero element has sign 0 so it reads as positive
    always_comb begin
        case (opc_reg[1:0])
            TEST_ZERO[1:0]: cond = (i_source_vector_reg == 64'h0);
            TEST_NONZERO[1:0]: cond = (i_source_vector_reg != 64'h0);
            TEST_POS[1:0]: cond = ~i_source_vector_reg[SIGN_BIT];
            default: cond = i_source_vector_reg[SIGN_BIT];
        endcase
    end

    // coarse reciprocal: negate exponent, invert leading coefficient bits.
    // accuracy is only a seed for a refinement step; zero or unnormalized
    // inputs give garbage, which is acceptable
    always_comb begin
        exp_in = i_source_vector_reg[EXP_HI:EXP_LO];
        top = i_source_vector_reg[COEF_HI-1 -: RECIP_TBL_BITS];
        rtop = {1'b0, ~top};
        recip = 64'h0;
        recip[SIGN_BIT] = i_source_vector_reg[SIGN_BIT];
        recip[EXP_HI:EXP_LO] = 15'(EXP_BIAS2 - exp_in);
        recip[COEF_NORM_BIT] = 1'b1;
        recip[COEF_HI-1 -: RECIP_TBL_BITS] = rtop[RECIP_TBL_BITS-1:0];
    end

    always_comb begin
        state_next = state_reg;
        is_test_next = is_test_reg;
        opc_next = opc_reg;
        len_next = len_reg;
        cnt_next = cnt_reg;
        list_next = list_reg;
        mask_next = mask_reg;
        we_next = 1'b0;
        widx_next = widx_reg;
        wdata_next = wdata_reg;
        done_next = 1'b0;
        unit_next = unit_reg;
        case (state_reg)
            VRPM_IDLE: begin
                // host writes only land while idle, so a running test owns the mask
                if (i_mask_wr) begin
                    mask_next = i_mask_wdata;
                end
                if (i_start) begin
                    is_test_next = i_is_test;
                    opc_next = i_opcode;
                    len_next = i_vector_length_reg;
                    cnt_next = 7'h00;
                    list_next = 6'h00;
                    unit_next = i_is_test ? VRPM_UNIT_LOGIC : VRPM_UNIT_RECIP;
                    // clear first so bits past the length read as zero
                    if (i_is_test) begin
                        mask_next = MASK_RESET;
                    end
                    state_next = (i_vector_length_reg == 7'h00) ? VRPM_DONE : VRPM_RUN;
                end
            end
            VRPM_RUN: begin
                if (is_test_reg) begin
                    // element n lands in bit 63-n, i.e. counted from the left
                    mask_next[NUM_ELEM-1-int'(cnt_reg[IDX_W-1:0])] = cond;
                    if ((opc_reg & TEST_LIST_BIT) != 3'h0 && cond) begin
                        we_next = 1'b1;
                        widx_next = list_reg;
                        wdata_next = {58'h0, cnt_reg[IDX_W-1:0]};
                        list_next = list_reg + 6'h01;
                    end
                end else begin
                    we_next = 1'b1;
                    widx_next = cnt_reg[IDX_W-1:0];
                    // opcodes above parity fall through to the reciprocal seed
                    case (opc_reg)
                        OPC_POP: wdata_next = {57'h0, pop};
                        OPC_PARITY: wdata_next = {63'h0, pop[0]};
                        default: wdata_next = recip;
                    endcase
                end
                cnt_next = cnt_reg + 7'h01;
                if (cnt_reg + 7'h01 >= len_reg) begin
                    state_next = VRPM_DONE;
                end
            end
            VRPM_DONE: begin
                // busy drops with this pulse so a new start is taken at once
                done_next = 1'b1;
                state_next = VRPM_IDLE;
            end
            default: state_next = VRPM_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state_reg <= VRPM_IDLE;
            is_test_reg <= 1'b0;
            opc_reg <= 3'h0;
            len_reg <= 7'h00;
            cnt_reg <= 7'h00;
            list_reg <= 6'h00;
            mask_reg <= MASK_RESET;
            we_reg <= 1'b0;
            widx_reg <= 6'h00;
            wdata_reg <= 64'h0;
            done_reg <= 1'b0;
            unit_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            is_test_reg <= is_test_next;
            opc_reg <= opc_next;
            len_reg <= len_next;
            cnt_reg <= cnt_next;
            list_reg <= list_next;
            mask_reg <= mask_next;
            we_reg <= we_next;
            widx_reg <= widx_next;
            wdata_reg <= wdata_next;
            done_reg <= done_next;
            unit_reg <= unit_next;
        end
    end

    // source index is registered so the file read lines up one cycle ahead
    logic busy_reg;
    logic [IDX_W-1:0] sidx_reg;
    logic busy_next;
    logic [IDX_W-1:0] sidx_next;
    always_comb begin
        busy_next = (state_next != VRPM_IDLE);
        sidx_next = (state_next == VRPM_RUN) ? cnt_next[IDX_W-1:0] : 6'h00;
    end
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            busy_reg <= 1'b0;
            sidx_reg <= 6'h00;
        end else begin
            busy_reg <= busy_next;
            sidx_reg <= sidx_next;
        end
    end

    assign o_busy = busy_reg;
    assign o_done = done_reg;
    assign o_src_index = sidx_reg;
    assign o_dest_we = we_reg;
    assign o_dest_index = widx_reg;
    assign o_dest_vector_reg = wdata_reg;
    assign o_unit = unit_reg;
    assign o_vector_condition_mask = mask_reg;
endmodule
`default_nettype wire

// file: testbench/vrpm_vreg_model.sv
// source side of the vector register file
`timescale 1ns/100ps
`default_nettype none
module vrpm_vreg_model (
    input wire logic [5:0] i_src_index,
    output logic [63:0] o_src_data
);
    // zero, positive and negative words in turn; the read has no latency
    function automatic logic [63:0] elem_val(input int n);
        return n % 3 == 0 ? 64'h0 : n % 3 == 1 ? 64'(n) ^ 64'hf0 : ~64'(n * 5);
    endfunction
    assign o_src_data = elem_val(int'(i_src_index));
endmodule
`default_nettype wire

// file: testbench/vrpm_unit_props.sv
// port checker for the vector unit
`timescale 1ns/100ps
`default_nettype none
module vrpm_unit_props
    import vrpm_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic i_is_test,
    input wire logic [2:0] i_opcode,
    input wire logic [6:0] i_vector_length_reg,
    input wire logic [63:0] i_source_vector_reg,
    input wire logic i_mask_wr,
    input wire logic [63:0] i_mask_wdata,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_dest_we,
    input wire logic [5:0] o_dest_index,
    input wire logic [63:0] o_dest_vector_reg,
    input wire logic [1:0] o_unit,
    input wire logic [63:0] o_vector_condition_mask
);
    logic acc, ts_reg, ts_next;
    logic [2:0] op_reg, op_next;
    logic [6:0] vl_reg, vl_next;
    logic [7:0] cy_reg, cy_next, wc_reg, wc_next;
    // own copy of the accepted instruction, the unit keeps its copy hidden
    always_comb begin
        acc = i_start && !o_busy;
        ts_next = acc ? i_is_test : ts_reg;
        op_next = acc ? i_opcode : op_reg;
        vl_next = acc ? i_vector_length_reg : vl_reg;
        cy_next = acc ? 8'h1 : cy_reg + 8'h1;
        wc_next = acc ? 8'h0 : wc_reg + 8'(o_dest_we);
    end
    always_ff @(posedge i_mclk) begin
        {ts_reg, op_reg, vl_reg, cy_reg, wc_reg} <= {ts_next, op_next, vl_next, cy_next, wc_next};
    end
    default clocking dc @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    a_done_time: assert property (o_done |-> cy_reg == vl_reg + 8'h2)
        else $error("done off time");
    a_write_count: assert property (o_done && !ts_reg |-> wc_reg == vl_reg)
        else $error("write count");
    a_index_order: assert property (o_dest_we && !ts_reg |-> o_dest_index == wc_reg[5:0])
        else $error("index order");
    a_unit_pick: assert property (o_done |-> o_unit == (ts_reg ? 2'h2 : 2'h1))
        else $error("wrong unit");
    a_done_idle: assert property (o_done |-> !o_busy && !o_dest_we)
        else $error("done while busy");
    a_pop_value: assert property (o_dest_we && !ts_reg && op_reg == OPC_POP
        |-> o_dest_vector_reg == $countones($past(i_source_vector_reg))) else $error("pop");
    a_parity_value: assert property (o_dest_we && !ts_reg && op_reg == OPC_PARITY
        |-> o_dest_vector_reg == 64'(^$past(i_source_vector_reg))) else $error("parity");
    a_mask_tail: assert property (o_done && ts_reg
        |-> (o_vector_condition_mask << vl_reg) == 64'h0) else $error("mask tail");
    a_mask_write: assert property (i_mask_wr && !o_busy
        |=> o_vector_condition_mask == $past(i_mask_wdata)) else $error("mask write");
    c_pop: cover property (o_done && !ts_reg && op_reg == OPC_POP);
    c_list: cover property (o_done && ts_reg && op_reg[2]);
    c_empty: cover property (o_done && vl_reg == 7'h0);
endmodule
bind vrpm_unit vrpm_unit_props chk (.*);
`default_nettype wire

// file: testbench/vrpm_unit_tb_top.sv
// self-checking bench for the vector unit
`timescale 1ns/100ps
`default_nettype none
module vrpm_unit_tb_top;
    import vrpm_pkg::*;
    logic i_mclk = 1'h0, i_reset = 1'h1, i_start = 1'h0, i_is_test = 1'h0, i_mask_wr = 1'h0;
    logic [2:0] i_opcode = 3'h0;
    logic [6:0] i_vector_length_reg = 7'h0;
    logic [63:0] i_mask_wdata = 64'h0, i_source_vector_reg, o_dest_vector_reg;
    logic [63:0] o_vector_condition_mask, em, e;
    logic o_busy, o_done, o_dest_we, c;
    logic [5:0] o_src_index, o_dest_index;
    logic [1:0] o_unit;
    logic [63:0] dv [64];
    int n_wr, n_mismatch = 0, check_count = 0;
    always #2.5 i_mclk = ~i_mclk;
    vrpm_unit dut (.*);
    vrpm_vreg_model pm (.i_src_index(o_src_index), .o_src_data(i_source_vector_reg));
    always @(posedge i_mclk) begin
        if (i_start) n_wr <= 0;
        else if (o_dest_we) begin
            chk(64'(o_dest_index), 64'(n_wr));
            dv[n_wr] <= o_dest_vector_reg;
            n_wr <= n_wr + 1;
        end
    end
    task automatic chk(input logic [63:0] g, input logic [63:0] x);
        check_count++;
        if (g !== x) begin
            n_mismatch++;
            $display("BAD %0t %h %h", $time, g, x);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d bad %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // expectations rebuilt from the source pattern, never from the unit
    task automatic go(input logic t, input logic [2:0] op, input logic [6:0] vl);
        int k;
        @(negedge i_mclk);
        {i_is_test, i_opcode, i_vector_length_reg, i_start} = {t, op, vl, 1'h1};
        @(negedge i_mclk);
        i_start = 1'h0;
        chk(64'(o_busy), 64'h1);
        for (k = 0; k < 99 && o_done !== 1'h1; k++) @(negedge i_mclk);
        if (k == 99) begin
            n_mismatch++;
            wrap_up();
        end
        chk(64'(o_busy), 64'h0);
        em = 64'h0;
        k = 0;
        for (int n = 0; n < vl; n++) begin
            e = pm.elem_val(n);
            c = op[1] ? e[63] ^ !op[0] : (e == 64'h0) ^ op[0];
            em[63 - n] = c;
            if (t && op[2] && c) begin
                chk(dv[k], n);
                k++;
            end
            if (!t && op != OPC_RECIP) chk(dv[n], op == OPC_POP ? $countones(e) : ^e);
        end
        chk(n_wr, t ? k : vl);
        if (t) chk(o_vector_condition_mask, em);
        chk(o_unit, t ? VRPM_UNIT_LOGIC : VRPM_UNIT_RECIP);
        $display("test %0d %0d %0d done", t, op, vl);
    endtask
    initial begin
        repeat (16) @(negedge i_mclk);
        i_reset = 1'h0;
        chk(o_vector_condition_mask, MASK_RESET);
        for (int op = 0; op < 3; op++) go(1'h0, 3'(op), 7'(op * 30 + 3));
        go(1'h0, OPC_POP, 7'h40);
        go(1'h0, OPC_PARITY, 7'h0);
        for (int op = 0; op < 8; op++) begin
            @(negedge i_mclk);
            i_mask_wr = 1'h1;
            i_mask_wdata = '1;
            @(negedge i_mclk);
            i_mask_wr = 1'h0;
            chk(o_vector_condition_mask, '1);
            go(1'h1, 3'(op), 7'(op * 9 + 1));
        end
        wrap_up();
    end
endmodule
`default_nettype wire
